/* plsr_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// station management host: one decoded request per call, launched on
// the falling edge, taken on the next rising edge and released on the falling edge after it
module plsr_host_model (
  input  wire logic        mclk,
  output logic             mgmt_c45,
  output logic [4:0]       mgmt_devad,
  output logic [15:0]      mgmt_addr,
  output logic             mgmt_wr,
  output logic             mgmt_rd,
  output logic [15:0]      mgmt_wdata,
  input  wire logic [15:0] mgmt_rdata,
  input  wire logic        mgmt_ack,
  output int               ack_miss
);
  // idle bus at time zero
  initial begin
    mgmt_c45 = 1'b1;
    mgmt_devad = plsr_pkg::SUBSYS_DEVAD;
    mgmt_addr = 16'h0000;
    mgmt_wr = 1'b0;
    mgmt_rd = 1'b0;
    mgmt_wdata = 16'h0000;
    ack_miss = 0;
  end

  // released address and data lines show the inverse so stale values are never trusted
  task automatic access(input logic c45, input logic [4:0] dev, input logic [15:0] a,
                        input logic w, input logic [15:0] d, output logic [15:0] q);
    @(negedge mclk);
    mgmt_c45 = c45;
    mgmt_devad = dev;
    mgmt_addr = a;
    mgmt_wdata = d;
    mgmt_wr = w;
    mgmt_rd = !w;
    @(posedge mclk);
    if (mgmt_ack !== 1'b1) ack_miss++;
    @(negedge mclk);
    q = mgmt_rdata;
    mgmt_wr = 1'b0;
    mgmt_rd = 1'b0;
    mgmt_addr = ~a;
    mgmt_wdata = ~d;
  endtask

  // direct access always names the subsystem device
  task automatic c45_wr(input logic [15:0] a, input logic [15:0] d);
    logic [15:0] q;
    access(1'b1, plsr_pkg::SUBSYS_DEVAD, a, 1'b1, d, q);
  endtask

  task automatic c45_rd(input logic [15:0] a, output logic [15:0] q);
    access(1'b1, plsr_pkg::SUBSYS_DEVAD, a, 1'b0, 16'h0000, q);
  endtask

  // hosts without the long frame go through the pointer and data pair
  task automatic c22_wr(input logic [4:0] r, input logic [15:0] d);
    logic [15:0] q;
    access(1'b0, 5'h00, {11'h000, r}, 1'b1, d, q);
  endtask

  task automatic c22_rd(input logic [4:0] r, output logic [15:0] q);
    access(1'b0, 5'h00, {11'h000, r}, 1'b0, 16'h0000, q);
  endtask
endmodule
`default_nettype wire

/* plsr_pkg.sv */
`default_nettype none
package plsr_pkg;

  // ==========================================================
  // register addresses (clause 45 device 0x1e space)
  localparam logic [15:0] ADDR_LED_STRETCH_TIME      = 16'hbc00;
  localparam logic [15:0] ADDR_LED_POLARITY_INVERT   = 16'hbc01;
  localparam logic [15:0] ADDR_SUBSYSTEM_SOFT_RESET  = 16'hff0c;
  localparam logic [15:0] ADDR_SOFT_RESET_RESTRAP_EN = 16'hff0d;
  localparam logic [15:0] ADDR_SUBSYSTEM_IRQ_ENABLE  = 16'hff1d;
  localparam logic [15:0] ADDR_SUBSYSTEM_IRQ_LATCH   = 16'hff1e;
  localparam logic [15:0] ADDR_OUTPUT_CLOCK_CONFIG   = 16'hff1f;
  localparam logic [15:0] ADDR_REDUCED_GIG_IF_CONFIG = 16'hff23;
  localparam logic [15:0] ADDR_REDUCED_IF_CONFIG     = 16'hff24;
  localparam logic [15:0] ADDR_PHY_BASE_CONFIG       = 16'hff26;
  localparam logic [15:0] ADDR_PHY_INTERFACE_CONTROL = 16'hff27;
  localparam logic [15:0] ADDR_TEN_MEG_PREAMBLE_GEN  = 16'hff38;
  localparam logic [15:0] ADDR_GIG_IF_IO_CONTROL     = 16'hff3a;
  localparam logic [15:0] ADDR_CLOCK_IO_CONTROL      = 16'hff3b;
  localparam logic [15:0] ADDR_LINK_OUTPUT_INVERT    = 16'hff3c;
  localparam logic [15:0] ADDR_CLOCK_PIN_OVERRIDE    = 16'hff3d;
  localparam logic [15:0] ADDR_LINK_PIN_OVERRIDE     = 16'hff3e;
  localparam logic [15:0] ADDR_IRQ_PIN_OVERRIDE      = 16'hff3f;
  localparam logic [15:0] ADDR_INDICATOR_PIN_OVERRIDE = 16'hff41;

  // clause 22 indirect pair
  localparam logic [4:0]  C22_INDIRECT_ADDR = 5'h10;
  localparam logic [4:0]  C22_INDIRECT_DATA = 5'h11;
  localparam logic [4:0]  SUBSYS_DEVAD      = 5'h1e;

  // ==========================================================
  // reset values and field layout
  localparam logic [15:0] RST_LED_STRETCH_TIME = 16'h0011;
  localparam logic [15:0] RST_IRQ_ENABLE       = 16'h000e;
  localparam logic [15:0] RST_CLOCK_CONFIG     = 16'h0008;
  localparam logic [15:0] RST_GIG_IF_CONFIG    = 16'h0e07;
  localparam logic [15:0] RST_REDUCED_IF       = 16'h0116;
  localparam logic [15:0] RST_PHY_BASE         = 16'h0c86;
  localparam logic [15:0] RST_PHY_IF_CTRL      = 16'h0002;
  localparam logic [15:0] RST_GIG_IO_CTRL      = 16'h0005;
  localparam logic [15:0] RST_CLOCK_IO_CTRL    = 16'h0002;
  localparam logic [15:0] RST_ZERO             = 16'h0000;

  localparam logic [15:0] MASK_STRETCH     = 16'h003f;
  localparam logic [15:0] MASK_BIT0        = 16'h0001;
  localparam logic [15:0] MASK_IRQ_ENABLE  = 16'h0010;
  localparam logic [15:0] MASK_CLOCK_CFG   = 16'h003f;
  localparam int          HRD_RST_BIT      = 4;
  localparam logic [1:0]  STRETCH_SEL_PROG = 2'h3;
  localparam int          STRETCH_MS_PER_LSB = 8;

  // ==========================================================
  // timing
  localparam int MCLK_HZ       = 100_000_000;
  localparam int MS_TICK_CYC   = MCLK_HZ / 1000;
  localparam int SOFT_RST_CYC  = 4;

  // strap modes sampled on the indicator pin
  localparam logic [1:0] STRAP_MODE1 = 2'h0;
  localparam logic [1:0] STRAP_MODE2 = 2'h1;

endpackage
`default_nettype wire

/* plsr_regs.sv */
`timescale 1ns/1ns
`default_nettype none
module plsr_regs #(
  parameter int SOFT_RST_CYCLES = plsr_pkg::SOFT_RST_CYC,
  parameter int MS_TICK         = plsr_pkg::MS_TICK_CYC
) (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // management access, already decoded from the mdio frame
  input  wire logic        mgmt_c45,
  input  wire logic [4:0]  mgmt_devad,
  input  wire logic [15:0] mgmt_addr,
  input  wire logic        mgmt_wr,
  input  wire logic        mgmt_rd,
  input  wire logic [15:0] mgmt_wdata,
  output logic [15:0]      mgmt_rdata,
  output logic             mgmt_ack,
  // strap and indicator pins
  input  wire logic [1:0]  indicator_strap_mode,
  input  wire logic [1:0]  stretch_select_field,
  input  wire logic        indicator_activity,
  input  wire logic        indicator_pin_in,
  output logic             indicator_pin_out,
  output logic             indicator_pin_oe,
  output logic             strap_sample_req,
  output logic             subsystem_reset_busy
);
  initial begin
    if (SOFT_RST_CYCLES < 1) $error("soft reset length must be at least one cycle");
  end

  typedef enum logic [2:0] {
    PLSR_IDLE  = 3'b001,
    PLSR_RESET = 3'b010,
    PLSR_LOAD  = 3'b100
  } plsr_state_e;

  plsr_state_e state_reg;
  plsr_state_e state_next;
  logic [15:0] stretch_reg;
  logic        polarity_reg;
  logic        restrap_reg;
  logic        soft_reset_reg;
  logic        hrd_irq_en_reg;
  logic        hrd_irq_lat_reg;
  logic [15:0] clock_cfg_reg;
  logic [1:0]  strap_store_reg;
  logic        strap_taken_reg;
  logic        sense_level_reg;
  logic [15:0] ind_addr_reg;
  logic [$clog2(SOFT_RST_CYCLES+1)-1:0] rst_cnt_reg;
  logic        sel;
  logic [15:0] eff_addr;
  logic        wr_hit;
  logic        rd_hit;
  logic        c22_addr_wr;
  logic        load_defaults;
  logic        polarity_default;
  logic        stretched;
  logic [8:0]  stretch_ms;
  logic [15:0] rdata_next;
  localparam int HRD_RST_BIT_IDX = plsr_pkg::HRD_RST_BIT;

  // ==========================================================
  // access decode: clause 45 direct, or clause 22 indirect pair
  always_comb begin
    sel         = 1'b0;
    eff_addr    = mgmt_addr;
    c22_addr_wr = 1'b0;
    if (mgmt_c45) begin
      sel = (mgmt_devad == plsr_pkg::SUBSYS_DEVAD);
    end else if (mgmt_addr[4:0] == plsr_pkg::C22_INDIRECT_DATA &&
                 mgmt_addr[15:5] == '0) begin
      sel      = 1'b1;
      eff_addr = ind_addr_reg;
    end else if (mgmt_addr[4:0] == plsr_pkg::C22_INDIRECT_ADDR &&
                 mgmt_addr[15:5] == '0) begin
      c22_addr_wr = mgmt_wr;
    end
  end
  assign wr_hit   = sel && mgmt_wr && (state_reg == PLSR_IDLE);
  assign rd_hit   = sel && mgmt_rd;
  assign mgmt_ack = mgmt_wr || mgmt_rd;

  // indirect address pointer for clause 22 hosts
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ind_addr_reg <= 16'h0000;
    end else if (c22_addr_wr) begin
      ind_addr_reg <= mgmt_wdata;
    end
  end

  // ==========================================================
  // strap capture: first clocked edge after release, then on restrap
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      strap_taken_reg <= 1'b0;
      strap_store_reg <= 2'h0;
    end else if (!strap_taken_reg || (state_reg == PLSR_LOAD && restrap_reg)) begin
      strap_taken_reg <= 1'b1;
      strap_store_reg <= indicator_strap_mode;
    end
  end
  assign strap_sample_req = !strap_taken_reg || (state_reg == PLSR_LOAD && restrap_reg);

  // defaults load once after hardware reset and at the end of each soft reset
  assign load_defaults = !strap_taken_reg || (state_reg == PLSR_LOAD);
  always_comb begin
    polarity_default = 1'b1;
    if (state_reg == PLSR_LOAD && restrap_reg) begin
      polarity_default = !(indicator_strap_mode == plsr_pkg::STRAP_MODE1 ||
                           indicator_strap_mode == plsr_pkg::STRAP_MODE2);
    end else if (state_reg == PLSR_LOAD) begin
      polarity_default = !(strap_store_reg == plsr_pkg::STRAP_MODE1 ||
                           strap_store_reg == plsr_pkg::STRAP_MODE2);
    end else begin
      polarity_default = !(indicator_strap_mode == plsr_pkg::STRAP_MODE1 ||
                           indicator_strap_mode == plsr_pkg::STRAP_MODE2);
    end
  end

  // ==========================================================
  // soft reset sequence
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      PLSR_IDLE: begin
        if (soft_reset_reg) begin
          state_next = PLSR_RESET;
        end
      end
      PLSR_RESET: begin
        if (rst_cnt_reg == '0) begin
          state_next = PLSR_LOAD;
        end
      end
      PLSR_LOAD: begin
        state_next = PLSR_IDLE;
      end
    endcase
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= PLSR_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_cnt_reg <= '0;
    end else if (state_reg == PLSR_IDLE) begin
      rst_cnt_reg <= ($clog2(SOFT_RST_CYCLES+1))'(SOFT_RST_CYCLES - 1);
    end else if (rst_cnt_reg != '0) begin
      rst_cnt_reg <= rst_cnt_reg - 1'b1;
    end
  end
  assign subsystem_reset_busy = (state_reg != PLSR_IDLE);

  // self-clearing soft reset bit, held until the sequence ends
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      soft_reset_reg <= 1'b0;
    end else if (state_reg == PLSR_LOAD) begin
      soft_reset_reg <= 1'b0;
    end else if (wr_hit && eff_addr == plsr_pkg::ADDR_SUBSYSTEM_SOFT_RESET) begin
      soft_reset_reg <= mgmt_wdata[0];
    end
  end

  // ==========================================================
  // writable registers; reserved bits masked off on write
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stretch_reg  <= plsr_pkg::RST_LED_STRETCH_TIME;
      polarity_reg <= 1'b0;
      restrap_reg  <= 1'b0;
      hrd_irq_en_reg <= 1'b0;
      clock_cfg_reg  <= plsr_pkg::RST_CLOCK_CONFIG;
    end else if (load_defaults) begin
      stretch_reg    <= plsr_pkg::RST_LED_STRETCH_TIME;
      polarity_reg   <= polarity_default;
      hrd_irq_en_reg <= 1'b0;
      clock_cfg_reg  <= plsr_pkg::RST_CLOCK_CONFIG;
    end else if (wr_hit) begin
      unique case (eff_addr)
        plsr_pkg::ADDR_LED_STRETCH_TIME:
          stretch_reg <= mgmt_wdata & plsr_pkg::MASK_STRETCH;
        plsr_pkg::ADDR_LED_POLARITY_INVERT:
          polarity_reg <= mgmt_wdata[0];
        plsr_pkg::ADDR_SOFT_RESET_RESTRAP_EN:
          restrap_reg <= mgmt_wdata[0];
        plsr_pkg::ADDR_SUBSYSTEM_IRQ_ENABLE:
          hrd_irq_en_reg <= mgmt_wdata[HRD_RST_BIT_IDX];
        plsr_pkg::ADDR_OUTPUT_CLOCK_CONFIG:
          clock_cfg_reg <= mgmt_wdata & plsr_pkg::MASK_CLOCK_CFG;
        default: begin
        end
      endcase
    end
  end

  // hardware reset flag: set by reset release, cleared by a read (set wins)
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hrd_irq_lat_reg <= 1'b0;
    end else if (!strap_taken_reg) begin
      hrd_irq_lat_reg <= 1'b1;
    end else if (rd_hit && eff_addr == plsr_pkg::ADDR_SUBSYSTEM_IRQ_LATCH) begin
      hrd_irq_lat_reg <= 1'b0;
    end
  end

  // ==========================================================
  // read mux; listed but unmodelled registers return reset values
  always_comb begin
    rdata_next = 16'h0000;
    unique case (eff_addr)
      plsr_pkg::ADDR_LED_STRETCH_TIME:      rdata_next = stretch_reg;
      plsr_pkg::ADDR_LED_POLARITY_INVERT:   rdata_next = {15'h0000, polarity_reg};
      plsr_pkg::ADDR_SUBSYSTEM_SOFT_RESET:  rdata_next = {15'h0000, soft_reset_reg};
      plsr_pkg::ADDR_SOFT_RESET_RESTRAP_EN: rdata_next = {15'h0000, restrap_reg};
      plsr_pkg::ADDR_SUBSYSTEM_IRQ_ENABLE:
        rdata_next = plsr_pkg::RST_IRQ_ENABLE |
                     (hrd_irq_en_reg ? plsr_pkg::MASK_IRQ_ENABLE : 16'h0000);
      plsr_pkg::ADDR_SUBSYSTEM_IRQ_LATCH:
        rdata_next = hrd_irq_lat_reg ? plsr_pkg::MASK_IRQ_ENABLE : 16'h0000;
      plsr_pkg::ADDR_OUTPUT_CLOCK_CONFIG:   rdata_next = clock_cfg_reg;
      plsr_pkg::ADDR_REDUCED_GIG_IF_CONFIG: rdata_next = plsr_pkg::RST_GIG_IF_CONFIG;
      plsr_pkg::ADDR_REDUCED_IF_CONFIG:     rdata_next = plsr_pkg::RST_REDUCED_IF;
      plsr_pkg::ADDR_PHY_BASE_CONFIG:       rdata_next = plsr_pkg::RST_PHY_BASE;
      plsr_pkg::ADDR_PHY_INTERFACE_CONTROL: rdata_next = plsr_pkg::RST_PHY_IF_CTRL;
      plsr_pkg::ADDR_GIG_IF_IO_CONTROL:     rdata_next = plsr_pkg::RST_GIG_IO_CTRL;
      plsr_pkg::ADDR_CLOCK_IO_CONTROL:      rdata_next = plsr_pkg::RST_CLOCK_IO_CTRL;
      default:                              rdata_next = plsr_pkg::RST_ZERO;
    endcase
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mgmt_rdata <= 16'h0000;
    end else if (rd_hit) begin
      mgmt_rdata <= rdata_next;
    end
  end

  // ==========================================================
  // indicator output: stretch only in programmable mode
  assign stretch_ms = 9'(stretch_reg[5:0] * plsr_pkg::STRETCH_MS_PER_LSB);
  plsr_stretch #(
    .MS_TICK (MS_TICK)
  ) u_stretch (
    .mclk       (mclk),
    .reset_n    (reset_n),
    .activity   (indicator_activity),
    .stretch_ms (stretch_ms),
    .stretched  (stretched)
  );

  // the pin floats while the soft reset sequence runs so its pull level can be sensed
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      indicator_pin_out <= 1'b0;
    end else begin
      indicator_pin_out <= ((stretch_select_field == plsr_pkg::STRETCH_SEL_PROG) ?
                            stretched : indicator_activity) ^ polarity_reg;
    end
  end
  assign indicator_pin_oe = subsystem_reset_busy;

  // sensed wiring level while released
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sense_level_reg <= 1'b0;
    end else if (subsystem_reset_busy) begin
      sense_level_reg <= indicator_pin_in;
    end
  end

  // ==========================================================
  // checks
  property p_selfclear;
    @(posedge mclk) disable iff (!reset_n)
      (state_reg == PLSR_LOAD) |=> !soft_reset_reg;
  endproperty
  a_selfclear: assert property (p_selfclear) else $error("soft reset bit stuck");

  property p_restrap;
    @(posedge mclk) disable iff (!reset_n)
      (state_reg == PLSR_LOAD && restrap_reg) |=>
        strap_store_reg == $past(indicator_strap_mode);
  endproperty
  a_restrap: assert property (p_restrap) else $error("no strap resample");

  property p_reload;
    @(posedge mclk) disable iff (!reset_n)
      (state_reg == PLSR_LOAD && !restrap_reg) |=>
        polarity_reg == !($past(strap_store_reg) < 2'h2);
  endproperty
  a_reload: assert property (p_reload) else $error("stored strap not reloaded");

  property p_irq_clear;
    @(posedge mclk) disable iff (!reset_n)
      (strap_taken_reg && rd_hit && eff_addr == plsr_pkg::ADDR_SUBSYSTEM_IRQ_LATCH)
        |=> !hrd_irq_lat_reg;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq flag not cleared");

  property p_polarity;
    @(posedge mclk) disable iff (!reset_n)
      (stretch_select_field != plsr_pkg::STRETCH_SEL_PROG) |=>
        indicator_pin_out == ($past(indicator_activity) ^ $past(polarity_reg));
  endproperty
  a_polarity: assert property (p_polarity) else $error("indicator polarity wrong");

  property p_reserved;
    @(posedge mclk) disable iff (!reset_n)
      stretch_reg[15:6] == '0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");

  property p_seq_len;
    @(posedge mclk) disable iff (!reset_n)
      (state_reg == PLSR_IDLE && soft_reset_reg) |=>
        subsystem_reset_busy[*5] ##1 !subsystem_reset_busy;
  endproperty
  a_seq_len: assert property (p_seq_len) else $error("soft reset length wrong");

  property p_devad;
    @(posedge mclk) disable iff (!reset_n)
      (mgmt_c45 && mgmt_devad != plsr_pkg::SUBSYS_DEVAD) |-> !wr_hit;
  endproperty
  a_devad: assert property (p_devad) else $error("foreign devad accepted");

  // the released pin level must be captured while the sequence runs
  property p_sense;
    @(posedge mclk) disable iff (!reset_n)
      subsystem_reset_busy |=> sense_level_reg == $past(indicator_pin_in);
  endproperty
  a_sense: assert property (p_sense) else $error("pin level not sensed");
endmodule
`default_nettype wire

/* plsr_stretch.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// pulse stretcher: holds a one-cycle activity event for a number of ms
module plsr_stretch #(
  parameter int MS_TICK = plsr_pkg::MS_TICK_CYC
) (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       activity,
  input  wire logic [8:0] stretch_ms,
  output logic            stretched
);
  initial begin
    if (MS_TICK < 1) $error("ms tick must be at least one cycle");
  end

  logic [$clog2(MS_TICK+1)-1:0] div_reg;
  logic                         tick;
  logic [8:0]                   ms_left_reg;

  // ms enable pulse from a free divider
  assign tick = (div_reg == '0);
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      div_reg <= '0;
    end else if (tick) begin
      div_reg <= ($clog2(MS_TICK+1))'(MS_TICK - 1);
    end else begin
      div_reg <= div_reg - 1'b1;
    end
  end

  // reload on activity, so a busy line stays lit
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ms_left_reg <= '0;
    end else if (activity) begin
      ms_left_reg <= stretch_ms;
    end else if (tick && ms_left_reg != '0) begin
      ms_left_reg <= ms_left_reg - 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stretched <= 1'b0;
    end else begin
      stretched <= activity || (ms_left_reg != '0);
    end
  end
endmodule
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fail_count++; \
  $display("[ERR] %0t mismatch got %h exp %h", $time, (got), (exp)); end end
module testbench;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic        mgmt_c45;
  logic [4:0]  mgmt_devad;
  logic [15:0] mgmt_addr;
  logic        mgmt_wr;
  logic        mgmt_rd;
  logic [15:0] mgmt_wdata;
  logic [15:0] mgmt_rdata;
  logic        mgmt_ack;
  logic [1:0]  indicator_strap_mode = 2'h0;
  logic [1:0]  stretch_select_field = 2'h3;
  logic        indicator_activity = 1'b0;
  wire logic   indicator_pin_in;
  logic        indicator_pin_out;
  logic        indicator_pin_oe;
  logic        strap_sample_req;
  logic        subsystem_reset_busy;
  int          fail_count = 0;
  int          tests_run = 0;
  int          req_n = 0;
  logic [15:0] rst_addr [8] = '{16'hbc00, 16'hbc01, 16'hff0c, 16'hff0d,
                                16'hff1d, 16'hff1f, 16'hff26, 16'hff41};
  logic [15:0] rst_val [8] = '{16'h0011, 16'h0000, 16'h0000, 16'h0000,
                               16'h000e, 16'h0008, 16'h0c86, 16'h0000};

  always #5 mclk = ~mclk;

  // indicator line has a pull-up, so a released pin reads high
  assign indicator_pin_in = indicator_pin_oe ? 1'b1 : indicator_pin_out;

  // short ms tick keeps the stretch windows under two hundred cycles
  plsr_regs #(.MS_TICK(10)) dut (
    .mclk                 (mclk),
    .reset_n              (reset_n),
    .mgmt_c45             (mgmt_c45),
    .mgmt_devad           (mgmt_devad),
    .mgmt_addr            (mgmt_addr),
    .mgmt_wr              (mgmt_wr),
    .mgmt_rd              (mgmt_rd),
    .mgmt_wdata           (mgmt_wdata),
    .mgmt_rdata           (mgmt_rdata),
    .mgmt_ack             (mgmt_ack),
    .indicator_strap_mode (indicator_strap_mode),
    .stretch_select_field (stretch_select_field),
    .indicator_activity   (indicator_activity),
    .indicator_pin_in     (indicator_pin_in),
    .indicator_pin_out    (indicator_pin_out),
    .indicator_pin_oe     (indicator_pin_oe),
    .strap_sample_req     (strap_sample_req),
    .subsystem_reset_busy (subsystem_reset_busy)
  );

  plsr_host_model host (
    .mclk       (mclk),
    .mgmt_c45   (mgmt_c45),
    .mgmt_devad (mgmt_devad),
    .mgmt_addr  (mgmt_addr),
    .mgmt_wr    (mgmt_wr),
    .mgmt_rd    (mgmt_rd),
    .mgmt_wdata (mgmt_wdata),
    .mgmt_rdata (mgmt_rdata),
    .mgmt_ack   (mgmt_ack),
    .ack_miss   ()
  );

  // count cycles in which the strap pins are being taken
  always @(posedge mclk) begin
    if (strap_sample_req === 1'b1) req_n <= req_n + 1;
  end

  task print_verdict;
    $display("counts: %0d compared, %0d mismatched", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // bounded wait for the soft reset sequence to finish
  task wait_idle;
    int i;
    for (i = 0; i < 40 && subsystem_reset_busy !== 1'b0; i++) @(negedge mclk);
    if (subsystem_reset_busy !== 1'b0) begin
      fail_count++;
      $display("[ERR] %0t soft reset never finished", $time);
      print_verdict;
    end
  endtask

  // one activity pulse; lit before the stretch ends, dark after it
  task automatic stretch_chk(input logic [15:0] fld, input logic pol, input int lit, input int dark);
    host.c45_wr(16'hbc00, fld);
    host.c45_wr(16'hbc01, {15'h0000, pol});
    @(negedge mclk);
    `CHK(indicator_pin_out, pol)
    indicator_activity = 1'b1;
    @(negedge mclk);
    indicator_activity = 1'b0;
    repeat (lit - 1) @(negedge mclk);
    `CHK(indicator_pin_out, ~pol)
    repeat (dark - lit) @(negedge mclk);
    `CHK(indicator_pin_out, pol)
  endtask

  // soft reset and wait for it; busy must be up mid-sequence
  task soft_reset;
    host.c45_wr(16'hff0c, 16'h0001);
    repeat (2) @(negedge mclk);
    `CHK(subsystem_reset_busy, 1'b1)
    `CHK(indicator_pin_oe, 1'b1)
    wait_idle();
  endtask

  initial begin
    logic [15:0] q;
    int i;
    int n0;
    repeat (10) @(negedge mclk);
    reset_n = 1'b1;
    // reset values, and the hardware reset flag that clears on read
    host.c45_rd(16'hff1e, q);
    `CHK(q, 16'h0010)
    host.c45_rd(16'hff1e, q);
    `CHK(q, 16'h0000)
    for (i = 0; i < 8; i++) begin
      host.c45_rd(rst_addr[i], q);
      `CHK(q, rst_val[i])
    end
    $display("test reset_values done");
    // reserved bits, unmapped place, foreign device, indirect pair
    host.c45_wr(16'hbc00, 16'hffff);
    host.c45_rd(16'hbc00, q);
    `CHK(q, 16'h003f)
    host.c45_wr(16'hbc01, 16'hfffe);
    host.c45_rd(16'hbc01, q);
    `CHK(q, 16'h0000)
    host.c45_wr(16'hff00, 16'h1234);
    host.c45_rd(16'hff00, q);
    `CHK(q, 16'h0000)
    host.access(1'b1, 5'h01, 16'hbc00, 1'b1, 16'h0007, q);
    host.c45_rd(16'hbc00, q);
    `CHK(q, 16'h003f)
    host.c22_wr(5'h10, 16'hbc00);
    host.c22_wr(5'h11, 16'h0005);
    host.c45_rd(16'hbc00, q);
    `CHK(q, 16'h0005)
    host.c22_rd(5'h11, q);
    `CHK(q, 16'h0005)
    $display("test access_paths done");
    // stretch length scales with the field; polarity flips the output
    stretch_chk(16'h0001, 1'b0, 60, 100);
    stretch_chk(16'h0002, 1'b0, 140, 180);
    stretch_chk(16'h0001, 1'b1, 60, 100);
    // outside programmable mode the pin follows activity with no stretch
    stretch_select_field = 2'h0;
    indicator_activity = 1'b1;
    @(negedge mclk);
    indicator_activity = 1'b0;
    `CHK(indicator_pin_out, 1'b0)
    @(negedge mclk);
    `CHK(indicator_pin_out, 1'b1)
    stretch_select_field = 2'h3;
    $display("test indicator done");
    // fresh strap sample for every strap mode
    for (i = 0; i < 4; i++) begin
      indicator_strap_mode = i[1:0];
      n0 = req_n;
      host.c45_wr(16'hff0d, 16'h0001);
      soft_reset();
      host.c45_rd(16'hff0c, q);
      `CHK(q, 16'h0000)
      host.c45_rd(16'hbc01, q);
      `CHK(q, {15'h0000, i >= 2})
      `CHK(req_n > n0, 1'b1)
    end
    // reload path: pins now say mode 1 but stored mode 4 must come back
    indicator_strap_mode = 2'h0;
    host.c45_wr(16'hff0d, 16'h0000);
    host.c45_wr(16'hbc01, 16'h0000);
    host.c45_wr(16'hbc00, 16'h0005);
    n0 = req_n;
    soft_reset();
    host.c45_rd(16'hbc01, q);
    `CHK(q, 16'h0001)
    host.c45_rd(16'hbc00, q);
    `CHK(q, 16'h0011)
    `CHK(req_n == n0, 1'b1)
    `CHK(host.ack_miss, 0)
    $display("test soft_reset done");
    // second hardware reset with mode 4 strapped: fresh sample and flag
    indicator_strap_mode = 2'h3;
    reset_n = 1'b0;
    repeat (3) @(negedge mclk);
    reset_n = 1'b1;
    host.c45_rd(16'hbc01, q);
    `CHK(q, 16'h0001)
    host.c45_rd(16'hff1e, q);
    `CHK(q, 16'h0010)
    host.c45_rd(16'hbc00, q);
    `CHK(q, 16'h0011)
    $display("test hard_reset done");
    print_verdict;
  end
endmodule
`undef CHK
`default_nettype wire
